// File: common/multimode_timer_map.vh
// constants for the signal-start multimode timer
`ifndef MULTIMODE_TIMER_MAP_VH
`define MULTIMODE_TIMER_MAP_VH

`define MODE_ON_DELAY     3'h0
`define MODE_CYCLE_ON     3'h1
`define MODE_CYCLE_OFF    3'h2
`define MODE_SIG_OFF_DLY  3'h3
`define MODE_SIG_ONOFF    3'h4
`define MODE_ONE_SHOT     3'h5

`define TICK_NS           100000
`define CLK_NS            20
`define TICK_CYCLES       (`TICK_NS / `CLK_NS)
// last prescaler count, TICK_CYCLES - 1 held at the prescaler width
`define TICK_LAST         13'h1387
`define TICK_W            13
`define PRESET_W          24

`define ST_IDLE           4'h1
`define ST_TIMING         4'h2
`define ST_RELEASED       4'h4
`define ST_DONE           4'h8

`endif

// File: hw/multimode_timer.v
// signal-start multimode delay timer with changeover output
`timescale 1ns/100ps
`default_nettype none
`include "multimode_timer_map.vh"
module multimode_timer (
    input  wire                   clock,
    input  wire                   rst_n,
    input  wire                   startIn,
    input  wire [2:0]             modeSel,
    input  wire [`PRESET_W-1:0]   presetTicks,
    output reg                    contactNo,
    output reg                    contactNc,
    output reg                    power_lamp,
    output reg                    outLamp
);
    // rst_n stands for power: low means power removed
    localparam [3:0] IDLE     = `ST_IDLE;
    localparam [3:0] TIMING   = `ST_TIMING;
    localparam [3:0] RELEASED = `ST_RELEASED;
    localparam [3:0] DONE     = `ST_DONE;

    reg                     rstMeta_reg;
    reg                     rstSync_reg;
    reg  [`TICK_W-1:0]      preCnt_reg;
    reg  [`TICK_W-1:0]      preCnt_next;
    reg                     tick_reg;
    reg                     tick_next;
    reg  [`PRESET_W-1:0]    elapsed_reg;
    reg  [`PRESET_W-1:0]    elapsed_next;
    reg  [3:0]              state_reg;
    reg  [3:0]              state_next;
    reg                     out_reg;
    reg                     out_next;
    reg  [2:0]              mode_reg;
    reg  [2:0]              mode_next;
    reg                     startPrev_reg;
    reg                     primed_reg;
    wire [2:0]              mode;
    wire                    startRise;
    wire                    startFall;
    wire                    expired;

    // power-up leaves through two flops so every state flop quits reset on one edge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    // the mode is taken once at power-up; turning the selector under power
    // would otherwise change the meaning of a phase already running
    always @* begin
        mode_next = mode_reg;
        if (!primed_reg) begin
            mode_next = modeSel;
        end
    end

    // the first powered cycle still looks at the selector directly
    assign mode = primed_reg ? mode_reg : modeSel;

    // one tick per tick period; the prescaler restarts on every state change so
    // the first tick of a phase comes a full period after the edge that opened it
    always @* begin
        preCnt_next = preCnt_reg + 1'b1;
        tick_next   = 1'b0;
        if (state_next != state_reg) begin
            preCnt_next = {`TICK_W{1'b0}};
        end else if (preCnt_reg == `TICK_LAST) begin
            preCnt_next = {`TICK_W{1'b0}};
            tick_next   = 1'b1;
        end
    end

    always @(posedge clock or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            preCnt_reg <= {`TICK_W{1'b0}};
            tick_reg   <= 1'b0;
        end else begin
            preCnt_reg <= preCnt_next;
            tick_reg   <= tick_next;
        end
    end

    assign startRise = startIn & ~startPrev_reg & primed_reg;
    assign startFall = ~startIn & startPrev_reg & primed_reg;
    // a preset of zero expires on the first tick rather than never
    assign expired   = tick_reg && (elapsed_reg + 1'b1 >= presetTicks);

    // idle waits for a start, timing runs a phase, released runs the off-delay,
    // done holds the output until the start input falls
    always @* begin
        state_next   = state_reg;
        out_next     = out_reg;
        elapsed_next = elapsed_reg;
        if (tick_reg) begin
            elapsed_next = elapsed_reg + 1'b1;
        end
        case (state_reg)
            IDLE: begin
                elapsed_next = {`PRESET_W{1'b0}};
                if (!primed_reg && startIn && mode == `MODE_SIG_OFF_DLY) begin
                    // a start already held when power arrives counts only in this mode
                    out_next   = 1'b1;
                    state_next = DONE;
                end else if (startRise) begin
                    state_next = TIMING;
                    case (mode)
                        `MODE_ON_DELAY:    out_next = 1'b0;
                        `MODE_CYCLE_ON:    out_next = 1'b1;
                        `MODE_CYCLE_OFF:   out_next = 1'b0;
                        `MODE_SIG_OFF_DLY: begin
                            out_next   = 1'b1;
                            state_next = DONE;
                        end
                        `MODE_SIG_ONOFF:   out_next = 1'b1;
                        `MODE_ONE_SHOT:    out_next = 1'b1;
                        default:           state_next = IDLE;
                    endcase
                end
            end
            TIMING: begin
                if (startFall && mode == `MODE_SIG_ONOFF) begin
                    out_next     = 1'b1;
                    elapsed_next = {`PRESET_W{1'b0}};
                    state_next   = RELEASED;
                end else if (startFall && mode != `MODE_ONE_SHOT) begin
                    out_next   = 1'b0;
                    state_next = IDLE;
                end else if (expired) begin
                    elapsed_next = {`PRESET_W{1'b0}};
                    case (mode)
                        `MODE_ON_DELAY: begin
                            out_next   = 1'b1;
                            state_next = DONE;
                        end
                        `MODE_CYCLE_ON, `MODE_CYCLE_OFF: out_next = ~out_reg;
                        `MODE_SIG_ONOFF: begin
                            out_next   = 1'b0;
                            state_next = DONE;
                        end
                        default: begin
                            out_next   = 1'b0;
                            // a shot whose start is already gone must not wait for a fall
                            state_next = startIn ? DONE : IDLE;
                        end
                    endcase
                end
            end
            RELEASED: begin
                if (startRise) begin
                    // a new start cancels the off-delay; the off-delay mode just holds on
                    out_next     = 1'b1;
                    elapsed_next = {`PRESET_W{1'b0}};
                    state_next   = (mode == `MODE_SIG_OFF_DLY) ? DONE : TIMING;
                end else if (expired) begin
                    out_next   = 1'b0;
                    state_next = IDLE;
                end
            end
            DONE: begin
                elapsed_next = {`PRESET_W{1'b0}};
                if (startFall) begin
                    case (mode)
                        `MODE_SIG_OFF_DLY: state_next = RELEASED;
                        `MODE_SIG_ONOFF: begin
                            out_next   = 1'b1;
                            state_next = RELEASED;
                        end
                        `MODE_ONE_SHOT: state_next = IDLE;
                        default: begin
                            out_next   = 1'b0;
                            state_next = IDLE;
                        end
                    endcase
                end
            end
            default: begin
                state_next = IDLE;
                out_next   = 1'b0;
            end
        endcase
    end

    always @(posedge clock or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            state_reg     <= IDLE;
            out_reg       <= 1'b0;
            elapsed_reg   <= {`PRESET_W{1'b0}};
            mode_reg      <= `MODE_ON_DELAY;
            startPrev_reg <= 1'b0;
            primed_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            out_reg       <= out_next;
            elapsed_reg   <= elapsed_next;
            mode_reg      <= mode_next;
            startPrev_reg <= startIn;
            primed_reg    <= 1'b1;
        end
    end

    // contacts and the output lamp are flops loaded with the next output value,
    // so they move on the same edge as the state they show
    always @(posedge clock or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            contactNo  <= 1'b0;
            contactNc  <= 1'b1;
            power_lamp <= 1'b0;
            outLamp    <= 1'b0;
        end else begin
            contactNo  <= out_next;
            contactNc  <= ~out_next;
            power_lamp <= 1'b1;
            outLamp    <= out_next;
        end
    end
endmodule // multimode_timer
`default_nettype wire

// File: dv/multimode_timer_props.sv
// concurrent checks on the multimode timer ports
`timescale 1ns/100ps
`default_nettype none
module multimode_timer_props (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       startIn,
    input wire logic [2:0] modeSel,
    input wire logic       contactNo,
    input wire logic       contactNc,
    input wire logic       power_lamp,
    input wire logic       outLamp);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_nc_inverse: assert property (contactNc == !contactNo) else $error("nc wrong");
    a_lamp_copy: assert property (outLamp == contactNo) else $error("lamp wrong");
    a_power_clear: assert property ($rose(rst_n) |-> !contactNo && !power_lamp) else $error("no clear");
    a_delay_wait: assert property (modeSel==3'h0 && $rose(startIn) |=> !contactNo[*8]) else $error("early");
    a_cycle_on: assert property (modeSel==3'h1 && $rose(startIn) |-> ##[1:2] contactNo) else $error("late");
    a_cycle_off: assert property (modeSel==3'h2 && $rose(startIn) |=> !contactNo[*8]) else $error("early");
    a_release_on: assert property (modeSel==3'h4 && $fell(startIn) |-> ##[1:2] contactNo) else $error("late");
    a_shot_hold: assert property (modeSel==3'h5 && $rose(contactNo) |=> contactNo[*8]) else $error("short");
    c_release: cover property (modeSel == 3'h4 && $fell(startIn));
    c_toggle: cover property (modeSel == 3'h1 && $fell(contactNo));
    c_power: cover property ($rose(rst_n));
endmodule // multimode_timer_props
bind multimode_timer multimode_timer_props i_props (.clock, .rst_n, .startIn, .modeSel, .contactNo, .contactNc,
    .power_lamp, .outLamp);
`default_nettype wire

// File: dv/start_control.sv
// machine control model driving the start contact
`timescale 1ns/100ps
`default_nettype none
module start_control (
    input  wire logic want,
    output wire logic startIn);
    assign startIn = want; // bounce-free contact, a real switch would chatter
endmodule // start_control
`default_nettype wire

// File: dv/multimode_timer_tb.sv
// self-checking bench for the multimode timer
`timescale 1ns/100ps
`default_nettype none
module multimode_timer_tb;
    logic       clock = 1'b0, rst_n = 1'b0, want = 1'b0;
    logic [2:0] modeSel = 3'h0;
    wire logic  startIn, contactNo, contactNc, power_lamp, outLamp;
    int         failures = 0, samples_checked = 0;
    initial forever #10 clock = ~clock;
    multimode_timer i_multimode_timer (.clock, .rst_n, .startIn, .modeSel, .presetTicks(24'h000001),
        .contactNo, .contactNc, .power_lamp, .outLamp);
    start_control i_start_control (.want, .startIn);
    // every sample also checks the closed contact and the output lamp against the open contact
    task automatic step(input int n, input logic [1:0] e);
        logic [3:0] got;
        repeat (n) @(negedge clock);
        got = {power_lamp, contactNo, contactNc, outLamp};
        samples_checked++;
        if (got !== {e, ~e[0], e[0]}) begin
            failures++;
            $display("FAIL %0t got %b want %b", $time, got, {e, ~e[0], e[0]});
        end
    endtask
    // samples sit mid-phase so the one-cycle slack of the timeout never decides
    task automatic phase(input logic [1:0] e1, input logic [1:0] e2);
        step(2500, e1);
        step(5000, e2);
    endtask
    task automatic power(input logic [2:0] m, input logic s);
        {rst_n, modeSel, want} <= {1'b0, m, s};
        step(2, 2'h0);
        rst_n <= 1'b1;
        repeat (4) @(negedge clock);
        want <= 1'b1;
    endtask
    task automatic final_report(input bit hang);
        failures += hang;
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_start;
        power(3'h0, 1'b0);
        phase(2'h2, 2'h3);
        power(3'h1, 1'b0);
        phase(2'h3, 2'h2);
        power(3'h2, 1'b0);
        phase(2'h2, 2'h3);
        power(3'h5, 1'b0);
        step(100, 2'h3);
        want <= 1'b0;
        phase(2'h3, 2'h2);
        want <= 1'b1;
        step(100, 2'h3);
    endtask
    // a start that returns during the off-delay keeps the output on while it stays held
    task automatic t_rearm;
        power(3'h3, 1'b1);
        step(100, 2'h3);
        want <= 1'b0;
        step(2500, 2'h3);
        want <= 1'b1;
        phase(2'h3, 2'h3);
    endtask
    task automatic t_release;
        power(3'h3, 1'b1);
        phase(2'h3, 2'h3);
        want <= 1'b0;
        phase(2'h3, 2'h2);
        power(3'h4, 1'b0);
        phase(2'h3, 2'h2);
        want <= 1'b0;
        phase(2'h3, 2'h2);
    endtask
    initial #2000000 final_report(1'b1);
    initial begin
        t_start;
        t_release;
        t_rearm;
        final_report(1'b0);
    end
endmodule // multimode_timer_tb
`default_nettype wire
